// *** verification/swl_chk.sv ***
// Port checker for the single-wire start-up listener.
// Assumes it is bound onto the top module; rst is synchronous, active high.
`timescale 1ns/1ps
module swl_chk
  import swl_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        shared_analog_output_pin,
  input wire logic        dedicated_link_input_pin,
  input wire logic        link_rx,
  input wire logic        link_listening,
  input wire logic        node_addressing_enable,
  input wire logic [7:0]  node_address
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Write: both halves taken at one edge with no answer pending; the held pair
  // is committed on the following edge, so bvalid is seen high two edges later
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_up;
    s_axi_bvalid;
  endsequence
  a_write_answer: assert property (both_taken && !s_axi_bvalid |-> ##2 resp_up)
    else $error("write response missing");
  a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  a_idle_high: assert property (!link_listening |-> link_rx)
    else $error("receive line not idle");
  a_rx_source: assert property (link_listening && link_rx |->
    shared_analog_output_pin || dedicated_link_input_pin) else $error("receive level wrong");
  // Reset result is checked even while reset is asserted, hence no disable
  a_reset_state: assert property (disable iff (1'b0) rst |=>
    node_address == NODE_ADDR_RESET && !node_addressing_enable && !link_listening)
    else $error("reset state wrong");
endmodule

// *** verification/swl_master.sv ***
// Model of the external single-wire master driving both link pins.
// Assumes the bench requests levels and start-up pulses just after an edge.
`timescale 1ns/1ps
module swl_master (
  input  wire logic clock,
  input  wire logic s_lvl,
  input  wire logic d_lvl,
  input  wire logic fire,
  output logic      shared_pin,
  output logic      dedicated_pin,
  output logic      startup_command
);
  // One register stage: a real line driver is never instant
  always_ff @(posedge clock) begin
    shared_pin      <= s_lvl;
    dedicated_pin   <= d_lvl;
    startup_command <= fire;
  end
endmodule

// *** verification/test_single_wire_startup_listener.sv ***
// Self-checking bench for the single-wire start-up listener.
// Assumes the window timer never runs out here; only the first window is used.
`timescale 1ns/1ps
module test_single_wire_startup_listener;
  import swl_pkg::*;
  logic        clock = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0]  awa = 0, ara = 0, node_address;
  logic [31:0] wd = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, sh, de, cmd, rx, ls, nen;
  logic        s_lvl = 1, d_lvl = 1, fire = 0;
  int          errors = 0, n_compared = 0;
  logic [1:0]  qb[$];
  logic [33:0] qr[$];
  always #50 clock = ~clock;
  single_wire_startup_listener DUT (.clock, .rst, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rr),
    .shared_analog_output_pin(sh), .dedicated_link_input_pin(de), .startup_command(cmd),
    .link_rx(rx), .link_listening(ls), .node_addressing_enable(nen), .node_address);
  swl_master pm (.clock, .s_lvl, .d_lvl, .fire, .shared_pin(sh), .dedicated_pin(de),
    .startup_command(cmd));
  task automatic chk(input logic [33:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 40) begin
      errors++;
      summarize;
    end
  endtask
  // Responses compared in the cycle before the edge that takes them
  always @(negedge clock) begin
    if (bvalid && br) chk(bresp, qb.pop_front());
    if (rvalid && rr) chk({rresp, rdata}, qr.pop_front());
  end
  // Readiness is sampled at the falling edge, where it is settled until the take
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    logic [2:0] t;
    @(posedge clock);
    qb.push_back(r);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    for (k = 0; k < 40; k++) begin
      @(negedge clock);
      t = {awv & awready, wv & wready, br & bvalid};
      @(posedge clock);
      if (t[2]) awv <= 0;
      if (t[1]) wv <= 0;
      if (t[0]) begin
        br <= 0;
        break;
      end
    end
    bound(k);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    logic [1:0] t;
    @(posedge clock);
    qr.push_back(e);
    ara <= a; arv <= 1; rr <= 1;
    for (k = 0; k < 40; k++) begin
      @(negedge clock);
      t = {arv & arready, rr & rvalid};
      @(posedge clock);
      if (t[1]) arv <= 0;
      if (t[0]) begin
        rr <= 0;
        break;
      end
    end
    bound(k);
  endtask
  task automatic pin(input logic s, d, input logic [2:0] m);
    logic on;
    on = (m != MODE_OFF);
    @(posedge clock);
    s_lvl <= s; d_lvl <= d;
    repeat (3) @(negedge clock);
    chk(ls, on);
    chk(rx, !on | (m == MODE_DIGITAL ? s : m == MODE_WINDOW ? s | d : d));
  endtask
  task automatic pulse;
    @(posedge clock);
    fire <= 1;
    @(posedge clock);
    fire <= 0;
  endtask
  initial begin
    logic [2:0] m;
    int j;
    void'($urandom(32'h112A));
    repeat (10) @(posedge clock);
    rst <= 0;
    rd(CTRL_OFFSET, {RESP_OKAY, 32'h0});
    rd(ADDR_OFFSET, {RESP_OKAY, 32'h28});
    wr(ADDR_OFFSET, 32'hFF5A, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h300, RESP_OKAY);
    rd(ADDR_OFFSET, {RESP_OKAY, 32'h5A});
    rd(CTRL_OFFSET, {RESP_OKAY, 32'h100});
    chk({nen, node_address}, 9'h15A);
    wr(8'h0C, 32'h1, RESP_SLVERR);
    rd(8'h0C, {RESP_SLVERR, 32'h0});
    // Every mode, random pin levels; checked in pin
    for (m = 0; m < 7; m++) begin
      wr(CTRL_OFFSET, 32'(m), RESP_OKAY);
      for (j = 0; j < 4; j++) pin(1'($urandom), 1'($urandom), m);
    end
    wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h11, RESP_OKAY);
    pulse;
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h07});
    wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
    pulse;
    rd(STATUS_OFFSET, {RESP_OKAY, 32'h0F});
    wr(CTRL_OFFSET, 32'h2, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h7, RESP_OKAY);
    rd(CTRL_OFFSET, {RESP_OKAY, 32'h2});
    summarize;
  end
endmodule
bind single_wire_startup_listener swl_chk u_chk (.clock, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .shared_analog_output_pin, .dedicated_link_input_pin, .link_rx,
  .link_listening, .node_addressing_enable, .node_address);

// *** verilog/single_wire_startup_listener.sv ***
// Start-up and listening logic of the single-wire configuration link.
// Assumes all pin inputs are synchronous to clock; protocol decoding lives elsewhere.
`timescale 1ns/1ps

// Operation
// - Mode off disables the link completely; pin activity is ignored.
// - Window mode accepts the start-up command on either pin only within the 200 ms window whose phase matches winsel.
// - Digital mode listens only on the shared analog-output pin.
// - Voltage mode, 5 V range, listens only on the dedicated link input pin.
// - Voltage mode, 10 V range, listens only on the dedicated link input pin.
// - Two-wire current loop listens only on the dedicated link input pin.
// - Group addressing unsupported; its enable stays off, its address is read-only.
// - Node addressing has an enable, disabled after reset.
// - Node address is writable and resets to 0x28.
module single_wire_startup_listener
  import swl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link pins (received levels)
  input  wire logic        shared_analog_output_pin,
  input  wire logic        dedicated_link_input_pin,
  // Start-up command recognised by the frame decoder
  input  wire logic        startup_command,
  // Towards the link decoder
  output logic             link_rx,
  output logic             link_listening,
  output logic             node_addressing_enable,
  output logic [7:0]       node_address
);

  // Registers
  link_mode_t  mode_q;
  logic        winsel_q;
  logic        node_en_q;
  logic [7:0]  node_addr_q;
  logic [31:0] win_cnt_q;
  logic        phase_q;        // Which window is running
  logic        started_q;
  logic        expired_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Pin selection per mode
  wire mode_window  = (mode_q == MODE_WINDOW);
  wire use_analog_output     = (mode_q == MODE_DIGITAL) || mode_window;
  wire use_dedic    = (mode_q == MODE_VOLT5) || (mode_q == MODE_VOLT10)
                    || (mode_q == MODE_LOOP2W) || (mode_q == MODE_LOOP3W)
                    || mode_window;
  wire win_open     = mode_window && !started_q && !expired_q;
  wire listen       = (mode_q != MODE_OFF) && (!mode_window || win_open || started_q);
  wire win_end      = (win_cnt_q == WINDOW_CYCLES - 1);
  wire in_chosen    = (phase_q == winsel_q);
  wire start_seen   = win_open && in_chosen && startup_command;

  // In single-pin modes the other pin is masked low out of the OR so its noise never reaches the decoder; window mode ORs both pins
  assign link_rx        = listen ? ((use_analog_output && shared_analog_output_pin)
                                   || (use_dedic && dedicated_link_input_pin)) : 1'b1;
  assign link_listening = listen;
  assign node_addressing_enable = node_en_q;
  assign node_address   = node_addr_q;

  // Window timer: two channel windows of 200 ms each, then silence
  always_ff @(posedge clock) begin
    if (rst || !mode_window || started_q || expired_q) begin
      win_cnt_q <= '0;
    end else if (win_end) begin
      win_cnt_q <= '0;
    end else begin
      win_cnt_q <= win_cnt_q + 32'h1;
    end
  end

  // Window phase, start-up capture and expiry
  always_ff @(posedge clock) begin
    if (rst || !mode_window) begin
      phase_q   <= 1'b0;
      started_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      if (start_seen) begin
        started_q <= 1'b1;
      end
      if (win_open && win_end && !start_seen) begin
        if (phase_q) begin
          expired_q <= 1'b1;
        end
        phase_q <= 1'b1;
      end
    end
  end

  // Write channel capture, address and data in either order
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Register writes; the group addressing bits are not stored at all
  wire wr_ctrl  = do_write && (awaddr_q[7:2] == CTRL_OFFSET[7:2]);
  wire wr_addr  = do_write && (awaddr_q[7:2] == ADDR_OFFSET[7:2]);
  wire wr_ok    = wr_ctrl || wr_addr || (awaddr_q[7:2] == STATUS_OFFSET[7:2]);
  wire [2:0] new_mode = wdata_q[MODE_LSB +: 3];
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q      <= link_mode_t'(MODE_RESET);
      winsel_q    <= 1'b0;
      node_en_q   <= 1'b0;
      node_addr_q <= NODE_ADDR_RESET;
    end else begin
      if (wr_ctrl && wstrb_q[0] && new_mode != 3'h7) begin
        mode_q   <= link_mode_t'(new_mode);
        winsel_q <= wdata_q[WINSEL_BIT];
      end
      if (wr_ctrl && wstrb_q[1]) begin
        node_en_q <= wdata_q[NODE_EN_BIT];
      end
      if (wr_addr && wstrb_q[0]) begin
        node_addr_q <= wdata_q[NODE_ADDR_LSB +: 8];
      end
    end
  end

  // Write response
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read mux
  logic [31:0] ctrl_word;
  logic [31:0] addr_word;
  logic [31:0] status_word;
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[MODE_LSB +: 3]  = mode_q;
    ctrl_word[WINSEL_BIT]     = winsel_q;
    ctrl_word[NODE_EN_BIT]    = node_en_q;
    ctrl_word[GROUP_EN_BIT]   = 1'b0;
    addr_word = 32'h0000_0000;
    addr_word[NODE_ADDR_LSB +: 8]  = node_addr_q;
    addr_word[GROUP_ADDR_LSB +: 8] = GROUP_ADDR_VALUE;
    status_word = 32'h0000_0000;
    status_word[ST_LISTEN_BIT]  = listen;
    status_word[ST_ANALOG_OUTPUT_BIT]    = listen && use_analog_output;
    status_word[ST_DEDIC_BIT]   = listen && use_dedic;
    status_word[ST_START_BIT]   = started_q;
    status_word[ST_EXPIRED_BIT] = expired_q;
    status_word[ST_PHASE_LSB]   = phase_q;
  end

  wire rd_ctrl = (s_axi_araddr[7:2] == CTRL_OFFSET[7:2]);
  wire rd_addr = (s_axi_araddr[7:2] == ADDR_OFFSET[7:2]);
  wire rd_stat = (s_axi_araddr[7:2] == STATUS_OFFSET[7:2]);
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_addr ? addr_word
                      : rd_stat ? status_word : 32'h0000_0000;
  wire do_read = s_axi_arvalid && !rvalid_q;

  // Read channel: one cycle to answer, held until taken
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (rd_ctrl || rd_addr || rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// *** verilog/swl_pkg.sv ***
// Package for the single-wire link start-up listener.
// Assumes a 10 MHz system clock and an AXI4-Lite register bus.
package swl_pkg;

  // Link mode field values
  typedef enum logic [2:0] {
    MODE_OFF     = 3'h0,
    MODE_WINDOW  = 3'h1,
    MODE_DIGITAL = 3'h2,
    MODE_VOLT5   = 3'h3,
    MODE_VOLT10  = 3'h4,
    MODE_LOOP2W  = 3'h5,
    MODE_LOOP3W  = 3'h6
  } link_mode_t;

  // Clock and window timing
  localparam int unsigned CLOCK_HZ          = 10_000_000;
  localparam int unsigned WINDOW_MS         = 200;
  localparam int unsigned WINDOW_CYCLES     = (CLOCK_HZ / 1000) * WINDOW_MS;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET        = 8'h00;
  localparam logic [7:0] ADDR_OFFSET        = 8'h04;
  localparam logic [7:0] STATUS_OFFSET      = 8'h08;

  // Control register fields
  localparam int unsigned MODE_LSB          = 0;
  localparam int unsigned WINSEL_BIT        = 4;
  localparam int unsigned NODE_EN_BIT       = 8;
  localparam int unsigned GROUP_EN_BIT      = 9;

  // Address register fields
  localparam int unsigned NODE_ADDR_LSB     = 0;
  localparam int unsigned GROUP_ADDR_LSB    = 8;

  // Status register fields
  localparam int unsigned ST_LISTEN_BIT     = 0;
  localparam int unsigned ST_ANALOG_OUTPUT_BIT       = 1;
  localparam int unsigned ST_DEDIC_BIT      = 2;
  localparam int unsigned ST_START_BIT      = 3;
  localparam int unsigned ST_EXPIRED_BIT    = 4;
  localparam int unsigned ST_PHASE_LSB      = 5;

  // Reset values
  localparam logic [2:0] MODE_RESET         = 3'h0;
  localparam logic [7:0] NODE_ADDR_RESET    = 8'h28;
  localparam logic [7:0] GROUP_ADDR_VALUE   = 8'h00; // Arbitrary fixed value

  // AXI response codes
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;

endpackage
